// File: core/afxc_ctrl.v
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "afxc_defs.vh"
// Host controller for an asynchronous 9-bit FIFO (or a width/depth array)
module afxc_ctrl #(
	parameter DW = 9
) (
	input  wire          ref_clk,
	input  wire          nrst,
	input  wire [11:0]   paddr,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [31:0]   pwdata,
	output reg  [31:0]   prdata,
	output reg           pready,
	output reg           pslverr,
	output reg           master_clear_n,
	output reg           write_n,
	output reg           read_n,
	output reg           first_load_or_retransmit_n,
	output reg  [DW-1:0] data_in,
	input  wire [DW-1:0] data_out,
	input  wire          empty_flag_n,
	input  wire          full_flag_n,
	input  wire          half_full_flag_n
);
	localparam S_IDLE = 5'b00001;
	localparam S_WR   = 5'b00010;
	localparam S_RD   = 5'b00100;
	localparam S_RST  = 5'b01000;
	localparam S_REC  = 5'b10000;

	reg [4:0]    state_q;
	reg [DW-1:0] wdata_q;
	reg [DW-1:0] rdata_q;
	reg          rdv_q;
	reg          refused_q;
	reg          casc_q;
	reg [7:0]    strobe_len_q;
	reg [7:0]    rec_q;
	reg          go_q;
	reg          clr_q;
	reg [7:0]    go_len_q;
	reg [2:0]    ef_s_q;
	reg [2:0]    ff_s_q;
	reg [1:0]    hf_s_q;
	reg [DW-1:0] dq1_q;
	reg [DW-1:0] dq2_q;
	wire         strobe_n;
	wire         done;

	// Flags and data come from an unclocked part: two flops first
	// flag pins: composite OR, or any one parallel device
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ef_s_q <= 3'h0;
			ff_s_q <= 3'h7;
			hf_s_q <= 2'h3;
			dq1_q  <= {DW{1'b0}};
			dq2_q  <= {DW{1'b0}};
		end
		else
		begin
			ef_s_q <= {ef_s_q[1], ef_s_q[0], empty_flag_n};
			ff_s_q <= {ff_s_q[1], ff_s_q[0], full_flag_n};
			hf_s_q <= {hf_s_q[0], half_full_flag_n};
			dq1_q  <= data_out;
			dq2_q  <= dq1_q;
		end
	end

	wire ef_ok = ef_s_q[1] & ef_s_q[2];
	wire ff_ok = ff_s_q[1] & ff_s_q[2];

	afxc_pulse #(.W(8)) u_pulse (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.start    (go_q),
		.len      (go_len_q),
		.strobe_n (strobe_n),
		.done     (done)
	);

	wire acc    = psel & penable;
	wire wr_acc = acc & pwrite;

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q        <= S_IDLE;
			wdata_q        <= {DW{1'b0}};
			rdata_q        <= {DW{1'b0}};
			rdv_q          <= 1'b0;
			refused_q      <= 1'b0;
			casc_q         <= 1'b0;
			strobe_len_q   <= `AFXC_STROBE_CYC;
			rec_q          <= 8'h00;
			go_q           <= 1'b0;
			clr_q          <= 1'b0;
			go_len_q       <= 8'h00;
			pready         <= 1'b0;
			pslverr        <= 1'b0;
			prdata         <= 32'h00000000;
			master_clear_n <= 1'b1;
			write_n        <= 1'b1;
			read_n         <= 1'b1;
			first_load_or_retransmit_n <= 1'b1;
			data_in        <= {DW{1'b0}};
		end
		else
		begin
			go_q    <= 1'b0;
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
				`AFXC_REG_CTRL:
					prdata <= {27'h0, casc_q, 4'h0};
				`AFXC_REG_WDATA:
					prdata <= {{(32-DW){1'b0}}, wdata_q};
				`AFXC_REG_RDATA:
					prdata <= {{(32-DW){1'b0}}, rdata_q};
				`AFXC_REG_STAT:
					prdata <= {26'h0, refused_q, rdv_q, hf_s_q[1],
						ff_s_q[1], ef_s_q[1], ~state_q[0]};
				`AFXC_REG_TIME:
					prdata <= {24'h0, strobe_len_q};
				default:
					prdata <= 32'h00000000;
				endcase
			end
			if (psel && !penable && paddr != `AFXC_REG_CTRL &&
				paddr != `AFXC_REG_WDATA && paddr != `AFXC_REG_RDATA &&
				paddr != `AFXC_REG_STAT && paddr != `AFXC_REG_TIME)
				pslverr <= 1'b1;
			if (wr_acc && paddr == `AFXC_REG_WDATA)
				wdata_q <= pwdata[DW-1:0];
			if (wr_acc && paddr == `AFXC_REG_TIME && pwdata[7:0] != 8'h00)
				strobe_len_q <= pwdata[7:0];
			if (acc && !pwrite && paddr == `AFXC_REG_RDATA)
				rdv_q <= 1'b0;
			if (wr_acc && paddr == `AFXC_REG_CTRL)
				casc_q <= pwdata[`AFXC_CTL_CASC];
			case (state_q)
			S_IDLE:
			begin
				if (wr_acc && paddr == `AFXC_REG_CTRL)
				begin
					refused_q <= 1'b0;
					go_len_q  <= strobe_len_q;
					if (pwdata[`AFXC_CTL_RST])
					begin
						go_q     <= 1'b1;
						clr_q    <= 1'b1;
						go_len_q <= `AFXC_RESET_CYC;
						state_q  <= S_RST;
					end
					// write only while full flag is high
					else if (pwdata[`AFXC_CTL_WR])
					begin
						if (ff_ok)
						begin
							go_q    <= 1'b1;
							// one word and strobe feed all parallel parts
							data_in <= wdata_q;
							state_q <= S_WR;
						end
						else
							refused_q <= 1'b1;
					end
					// read only while empty flag is high
					else if (pwdata[`AFXC_CTL_RD])
					begin
						if (ef_ok)
						begin
							go_q    <= 1'b1;
							state_q <= S_RD;
						end
						else
							refused_q <= 1'b1;
					end
					else if (pwdata[`AFXC_CTL_RT])
					begin
						if (!casc_q)
						begin
							go_q    <= 1'b1;
							clr_q   <= 1'b0;
							state_q <= S_RST;
						end
						else
							refused_q <= 1'b1;
					end
				end
			end
			S_WR:
			begin
				// word held until write strobe rises
				write_n <= strobe_n & ~go_q;
				if (done)
				begin
					write_n <= 1'b1;
					rec_q   <= `AFXC_RECOV_CYC;
					state_q <= S_REC;
				end
			end
			S_RD:
			begin
				read_n <= strobe_n & ~go_q;
				// sample while read strobe still low
				if (done)
				begin
					rdata_q <= dq2_q;
					rdv_q   <= 1'b1;
					read_n  <= 1'b1;
					rec_q   <= `AFXC_RECOV_CYC;
					state_q <= S_REC;
				end
			end
			S_RST:
			begin
				// Own flag, not the length, so any TIME value is safe
				if (clr_q)
				begin
					master_clear_n <= strobe_n & ~go_q;
					// level moves only under clear, never a resend
					if (!master_clear_n)
						first_load_or_retransmit_n <= ~casc_q;
				end
				else
					first_load_or_retransmit_n <= strobe_n & ~go_q;
				if (done)
				begin
					master_clear_n <= 1'b1;
					// first-load level kept static in cascade
					// chain wiring and paired units stay outside
					first_load_or_retransmit_n <= ~casc_q;
					rec_q   <= `AFXC_RECOV_CYC;
					state_q <= S_REC;
				end
			end
			S_REC:
			begin
				// Lets flag synchronisers settle before next decision
				if (rec_q == 8'h00)
					state_q <= S_IDLE;
				else
					rec_q <= rec_q - 8'h01;
			end
			default:
				state_q <= S_IDLE;
			endcase
		end
	end
endmodule

// File: core/afxc_defs.vh
`ifndef AFXC_DEFS_VH
`define AFXC_DEFS_VH
// Functional notes
// - Exactly one cascaded FIFO has first_load_n held low.
// - Every other cascaded FIFO has first_load_n held high.
// - Each chain_token_out_n feeds the next FIFO's chain_token_in_n.
// - Composite flags are the OR of all active-low device flags.
// - Width expansion drives all controls together; flags from any one device.
// - Writer toggles write strobe only while full flag is deasserted.
// - Bidirectional buffering pairs one FIFO per direction.

// Controller register byte offsets on APB
`define AFXC_REG_CTRL 12'h000
`define AFXC_REG_WDATA 12'h004
`define AFXC_REG_RDATA 12'h008
`define AFXC_REG_STAT 12'h00C
`define AFXC_REG_TIME 12'h010
// CTRL bits (write one to launch; bits 0-3 are self-clearing, CASC bit 4 is held)
`define AFXC_CTL_WR 0
`define AFXC_CTL_RD 1
`define AFXC_CTL_RST 2
`define AFXC_CTL_RT 3
`define AFXC_CTL_CASC 4
// STAT bits
`define AFXC_ST_BUSY 0
`define AFXC_ST_EMPTY_N 1
`define AFXC_ST_FULL_N 2
`define AFXC_ST_HALF_N 3
`define AFXC_ST_RDV 4
`define AFXC_ST_REFUSED 5
// Strobe low time and recovery, cycles
`define AFXC_STROBE_CYC 8'h04
`define AFXC_RECOV_CYC 8'h02
`define AFXC_RESET_CYC 8'h0A
`endif

// File: core/afxc_pulse.v
`timescale 1ns/10ps
// Drives one active-low strobe for a programmable number of cycles
module afxc_pulse #(
	parameter W = 8
) (
	input  wire         ref_clk,
	input  wire         nrst,
	input  wire         start,
	input  wire [W-1:0] len,
	output reg          strobe_n,
	output reg          done
);
	reg [W-1:0] cnt_q;

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			strobe_n <= 1'b1;
			cnt_q    <= {W{1'b0}};
			done     <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start && strobe_n)
			begin
				strobe_n <= 1'b0;
				cnt_q    <= len;
			end
			else if (!strobe_n)
			begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1})
				begin
					strobe_n <= 1'b1;
					done     <= 1'b1;
				end
				else
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// File: sim/afxc_props.sv
`timescale 1ns/10ps
module afxc_props #(
	parameter DW = 9
) (
	input wire logic          ref_clk,
	input wire logic          nrst,
	input wire logic          master_clear_n,
	input wire logic          write_n,
	input wire logic          read_n,
	input wire logic          first_load_or_retransmit_n,
	input wire logic [DW-1:0] data_in,
	input wire logic          empty_flag_n,
	input wire logic          full_flag_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wr_room_a: assert property (
		$fell(write_n) |-> full_flag_n && $past(full_flag_n))
		else $error("write strobe on full");
	rd_data_a: assert property (
		$fell(read_n) |-> empty_flag_n && $past(empty_flag_n))
		else $error("read strobe on empty");
	wr_len_a: assert property (
		$fell(write_n) |-> !write_n[*5] ##1 write_n)
		else $error("write strobe length");
	rd_len_a: assert property (
		$fell(read_n) |-> !read_n[*5] ##1 read_n)
		else $error("read strobe length");
	din_hold_a: assert property (
		!write_n |=> $stable(data_in))
		else $error("data moved under write");
	clr_idle_a: assert property (
		!master_clear_n |-> write_n && read_n)
		else $error("strobe during clear");
	clr_len_a: assert property (
		$fell(master_clear_n) |-> ##10 !master_clear_n ##1 master_clear_n)
		else $error("clear pulse length");
	rt_idle_a: assert property (
		$fell(first_load_or_retransmit_n) |-> write_n && read_n)
		else $error("strobe during retransmit");
	cover property ($fell(write_n));
	cover property ($fell(read_n));
	cover property ($fell(first_load_or_retransmit_n) && master_clear_n);
endmodule
bind afxc_ctrl afxc_props #(.DW(DW)) u_props (.*);

// File: sim/afxc_fifo_model.sv
`timescale 1ns/10ps
module afxc_fifo_model #(
	parameter D = 4
) (
	input  wire logic       master_clear_n,
	input  wire logic       write_n,
	input  wire logic       read_n,
	input  wire logic       first_load_or_retransmit_n,
	input  wire logic [8:0] data_in,
	output logic      [8:0] data_out,
	output wire logic       empty_flag_n,
	output wire logic       full_flag_n,
	output wire logic       half_full_flag_n
);
	logic [8:0] mem [D];
	int         wp = 0;
	int         rp = 0;
	int         cnt = 0;
	initial data_out = 9'h000;
	assign empty_flag_n = cnt != 0;
	assign full_flag_n = cnt != D;
	assign half_full_flag_n = cnt <= D / 2;
	always @(negedge master_clear_n)
	begin
		wp = 0;
		rp = 0;
		cnt = 0;
	end
	// store on rising write; a write while full is dropped
	always @(posedge write_n)
		if (master_clear_n && cnt < D)
		begin
			mem[wp] = data_in;
			wp = (wp + 1) % D;
			cnt++;
			// read already low on empty: word flows through
			if (!read_n && cnt == 1)
				data_out = data_in;
		end
	always @(negedge read_n)
		if (cnt > 0)
			data_out = mem[rp];
	// Released bus shows the inverse, never a stale match
	always @(posedge read_n)
	begin
		data_out = ~data_out;
		if (master_clear_n && cnt > 0)
		begin
			rp = (rp + 1) % D;
			cnt--;
		end
	end
	// read pointer home, write pointer kept
	always @(negedge first_load_or_retransmit_n)
		if (master_clear_n)
		begin
			rp = 0;
			cnt = wp;
		end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/10ps
`include "afxc_defs.vh"
module tb_top;
	logic        ref_clk = 0;
	logic        nrst = 0;
	logic [11:0] paddr = 12'h000;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        master_clear_n;
	logic        write_n;
	logic        read_n;
	logic        first_load_or_retransmit_n;
	logic [8:0]  data_in;
	logic [8:0]  data_out;
	logic        empty_flag_n;
	logic        full_flag_n;
	logic        half_full_flag_n;
	logic [31:0] rd;
	logic        err;
	int          miscompares = 0;
	int          n_tests = 0;
	logic [8:0]  dat [4] = '{9'h1A5, 9'h05A, 9'h100, 9'h0FF};
	logic [2:0]  fl [8] = '{3'h7, 3'h7, 3'h3, 3'h1, 3'h3, 3'h7, 3'h7, 3'h6};
	always #5 ref_clk = ~ref_clk;
	afxc_ctrl dut (.*);
	afxc_fifo_model u_dev (.*);
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input int d);
		int k = 0;
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && k++ < 20)
			@(posedge ref_clk);
		if (pready !== 1'b1)
			miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Poll busy so no command lands on a running strobe
	task automatic cmd(input int c);
		int k = 0;
		apb(1, `AFXC_REG_CTRL, c);
		do
			apb(0, `AFXC_REG_STAT, 0);
		while (rd[`AFXC_ST_BUSY] !== 1'b0 && k++ < 50);
		if (rd[`AFXC_ST_BUSY] !== 1'b0)
			miscompares++;
	endtask
	task automatic tally_and_finish;
		if (miscompares == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		#200us;
		miscompares++;
		tally_and_finish;
	end
	initial
	begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1;
		cmd(32'h4);
		chk("reset flags", rd[3:1], 3'h6);
		for (int i = 0; i < 8; i++)
		begin
			if (i < 4)
				apb(1, `AFXC_REG_WDATA, dat[i]);
			cmd(i < 4 ? 32'h1 : 32'h2);
			chk("flags", rd[3:1], fl[i]);
			if (i > 3)
			begin
				apb(0, `AFXC_REG_RDATA, 0);
				chk("data", rd, dat[i-4]);
			end
		end
		cmd(32'h2);
		chk("empty refuse", rd[5:1], 5'h16);
		for (int i = 0; i < 5; i++)
		begin
			apb(1, `AFXC_REG_WDATA, i);
			cmd(32'h1);
		end
		chk("full refuse", rd[5:1], 5'h11);
		cmd(32'h4);
		for (int i = 1; i < 3; i++)
		begin
			apb(1, `AFXC_REG_WDATA, 9'h011 * i);
			cmd(32'h1);
		end
		for (int i = 0; i < 2; i++)
		begin
			cmd(i ? 32'h8 : 32'h2);
			cmd(32'h2);
			apb(0, `AFXC_REG_RDATA, 0);
			chk("resend", rd, i ? 32'h11 : 32'h22);
		end
		apb(0, 12'hFFC, 0);
		chk("slverr", err, 1'b1);
		cmd(32'h14);
		chk("first load", first_load_or_retransmit_n, 1'b0);
		chk("casc flags", rd[2:1], 2'h2);
		cmd(32'h18);
		chk("casc resend", rd[5], 1'b1);
		chk("casc hold", first_load_or_retransmit_n, 1'b0);
		apb(1, `AFXC_REG_TIME, 0);
		apb(0, `AFXC_REG_TIME, 0);
		chk("strobe time", rd, `AFXC_STROBE_CYC);
		tally_and_finish;
	end
endmodule
